// ===== design/wdt_pkg.sv
package wdt_pkg;

	// register byte offsets on the apb slave
	localparam logic [7:0] TICK_CONTROL_OFS         = 8'h00;
	localparam logic [7:0] WATCHDOG_CONTROL_OFS     = 8'h04;
	localparam logic [7:0] FACTORY_TEST_BYPASS_OFS  = 8'h08;
	localparam logic [7:0] FACTORY_TEST_CONTROL_OFS = 8'h0C;
	localparam logic [7:0] WATCHDOG_RESTART_KEY_OFS = 8'h10;
	localparam logic [7:0] POWER_CONFIG_OFS         = 8'h14;
	localparam logic [7:0] TICK_STATUS_OFS          = 8'h18;

	// tick_control fields
	localparam int TICK_PRESCALE_LSB = 4;
	localparam int TICK_PRESCALE_MSB = 6;
	localparam int TICK_MODULUS_LSB  = 0;
	localparam int TICK_MODULUS_MSB  = 3;
	localparam logic [4:0] TICK_PRESCALE_BASE = 5'h09;

	// watchdog_control fields
	localparam int WINDOW_MODE_BIT = 7;
	localparam int DEBUG_STOP_BIT  = 6;
	localparam int RATE_LSB        = 0;
	localparam int RATE_MSB        = 2;

	// power_config fields
	localparam int TICK_WAIT_STOP_BIT     = 0;
	localparam int WDOG_WAIT_STOP_BIT     = 1;
	localparam int TICK_PSTOP_ENABLE_BIT  = 2;
	localparam int WDOG_PSTOP_ENABLE_BIT  = 3;
	localparam int TICK_IRQ_ENABLE_BIT    = 4;

	// restart keys
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;

	// reset values
	localparam logic [7:0] TICK_CONTROL_RST         = 8'h00;
	localparam logic [7:0] WATCHDOG_CONTROL_RST     = 8'h00;
	localparam logic [7:0] FACTORY_TEST_BYPASS_RST  = 8'h00;
	localparam logic [7:0] FACTORY_TEST_CONTROL_RST = 8'h80;
	localparam logic [7:0] POWER_CONFIG_RST         = 8'h00;

	// watchdog timeout exponents for rate codes 1..7
	localparam logic [4:0] WDOG_EXP_1 = 5'h0E;
	localparam logic [4:0] WDOG_EXP_2 = 5'h10;
	localparam logic [4:0] WDOG_EXP_3 = 5'h12;
	localparam logic [4:0] WDOG_EXP_4 = 5'h14;
	localparam logic [4:0] WDOG_EXP_5 = 5'h16;
	localparam logic [4:0] WDOG_EXP_6 = 5'h17;
	localparam logic [4:0] WDOG_EXP_7 = 5'h18;

	typedef struct packed {
		logic special;
		logic bdm_active;
		logic wait_mode;
		logic pseudo_stop;
	} wdt_mode_type;

endpackage : wdt_pkg

// ===== design/wdt_top.sv
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - any tick_control write restarts the tick counter from zero
// - prescale bits 6:4; 000 off, 001..111 select 2^10..2^16 cycles
// - modulus bits 3:0 multiply period by value plus one
// - tick counts the oscillator clock
// - prescale resets to 000, tick off; software uses 000 to disable
// - watchdog_control always readable; window/rate once in normal, debug-stop once
// - window mode: restart writes only in last quarter, earlier writes reset
// - debug-stop bit halts both counters during background debug mode
// - rate bits 2:0 select timeout 2^14..2^24 or disabled
// - nonzero rate write enables watchdog and starts a period
// - watchdog expiry without restart raises system reset
// - each period counts from completion of the key pair
// - restart key reads zero, writable any time
// - with rate 000 restart writes are ignored
// - enabled watchdog: non-key restart write resets immediately
// - repeated single keys tolerated; only first-then-second restarts
// - window mode: after a restart, wait for next window
// - factory bypass reads zero and is write-protected outside special modes
// - factory control reads 0x80 and is write-protected outside special modes
// - tick wait-stop: tick halts and clears in wait mode
// - watchdog wait-stop: watchdog halts and clears in wait mode
// - pseudo-stop freezes each counter unless its enable bit is set
module wdt_top (
	input  wire logic                  ref_clk,
	input  wire logic                  nrst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	input  wire wdt_pkg::wdt_mode_type mode,
	output logic                       tick_irq,
	output logic                       wdog_reset_req
);

	logic [7:0]  tick_control_ff;
	logic [7:0]  watchdog_control_ff;
	logic [7:0]  factory_test_bypass_ff;
	logic [7:0]  factory_test_control_ff;
	logic [7:0]  power_config_ff;
	logic        rate_written_ff;
	logic        dbg_written_ff;
	logic        wwait_written_ff;
	logic        tick_flag_ff;
	logic [20:0] tick_cnt_ff;
	logic [24:0] wdog_cnt_ff;
	logic        key_first_ff;
	logic        reset_req_ff;
	logic [31:0] prdata_ff;
	logic        slverr_ff;

	logic        wr_acc;
	logic        wr_tick_ctl;
	logic        wr_wdog_ctl;
	logic        wr_key;
	logic        wr_pcfg;
	logic        wr_status;
	logic        wr_ftb;
	logic        wr_ftc;
	logic        mapped;
	logic [7:0]  wdata;
	logic [2:0]  tick_pre;
	logic [3:0]  tick_mod;
	logic [20:0] tick_limit;
	logic        tick_run;
	logic        tick_clear;
	logic        tick_expire;
	logic [2:0]  wdog_rate;
	logic        wdog_on;
	logic [4:0]  wdog_exp;
	logic [24:0] wdog_limit;
	logic [24:0] wdog_open;
	logic        wdog_run;
	logic        wdog_clear;
	logic        key_bad;
	logic        key_early;
	logic        key_restart;
	logic        wdog_expire;
	logic        debug_halt;
	logic [31:0] nxt_prdata;

	// apb decode: one setup, one access cycle, no wait states
	assign wdata       = pwdata[7:0];
	assign wr_acc      = psel && penable && pwrite && pstrb[0];
	assign wr_tick_ctl = wr_acc && (paddr == wdt_pkg::TICK_CONTROL_OFS);
	assign wr_wdog_ctl = wr_acc && (paddr == wdt_pkg::WATCHDOG_CONTROL_OFS);
	assign wr_key      = wr_acc && (paddr == wdt_pkg::WATCHDOG_RESTART_KEY_OFS);
	assign wr_pcfg     = wr_acc && (paddr == wdt_pkg::POWER_CONFIG_OFS);
	assign wr_status   = wr_acc && (paddr == wdt_pkg::TICK_STATUS_OFS);
	assign wr_ftb      = wr_acc && (paddr == wdt_pkg::FACTORY_TEST_BYPASS_OFS) && mode.special;
	assign wr_ftc      = wr_acc && (paddr == wdt_pkg::FACTORY_TEST_CONTROL_OFS) && mode.special;
	assign mapped      = (paddr == wdt_pkg::TICK_CONTROL_OFS) || (paddr == wdt_pkg::WATCHDOG_CONTROL_OFS)
		|| (paddr == wdt_pkg::FACTORY_TEST_BYPASS_OFS) || (paddr == wdt_pkg::FACTORY_TEST_CONTROL_OFS)
		|| (paddr == wdt_pkg::WATCHDOG_RESTART_KEY_OFS) || (paddr == wdt_pkg::POWER_CONFIG_OFS)
		|| (paddr == wdt_pkg::TICK_STATUS_OFS);

	assign pready  = psel && penable;
	assign prdata  = prdata_ff;
	assign pslverr = slverr_ff && psel && penable;

	// read mux sampled in the setup cycle
	always_comb
	begin
		nxt_prdata = 32'h0000_0000;
		unique case (paddr)
			wdt_pkg::TICK_CONTROL_OFS:         nxt_prdata[7:0] = tick_control_ff;
			wdt_pkg::WATCHDOG_CONTROL_OFS:     nxt_prdata[7:0] = watchdog_control_ff;
			wdt_pkg::FACTORY_TEST_BYPASS_OFS:
				nxt_prdata[7:0] = mode.special ? factory_test_bypass_ff : 8'h00;
			wdt_pkg::FACTORY_TEST_CONTROL_OFS:
				nxt_prdata[7:0] = mode.special ? factory_test_control_ff : wdt_pkg::FACTORY_TEST_CONTROL_RST;
			wdt_pkg::WATCHDOG_RESTART_KEY_OFS: nxt_prdata[7:0] = 8'h00;
			wdt_pkg::POWER_CONFIG_OFS:         nxt_prdata[7:0] = power_config_ff;
			wdt_pkg::TICK_STATUS_OFS:          nxt_prdata[0]   = tick_flag_ff;
			default:                           nxt_prdata      = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prdata_ff <= 32'h0000_0000;
			slverr_ff <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
			slverr_ff <= !mapped;
		end
	end

	// tick control, writable any time
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			tick_control_ff <= wdt_pkg::TICK_CONTROL_RST;
		else if (wr_tick_ctl)
			tick_control_ff <= {1'b0, wdata[6:0]};
	end

	// watchdog control with write-once protection
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			watchdog_control_ff <= wdt_pkg::WATCHDOG_CONTROL_RST;
			rate_written_ff     <= 1'b0;
			dbg_written_ff      <= 1'b0;
		end
		else if (wr_wdog_ctl)
		begin
			if (mode.special || !rate_written_ff)
			begin
				watchdog_control_ff[wdt_pkg::WINDOW_MODE_BIT] <= wdata[wdt_pkg::WINDOW_MODE_BIT];
				watchdog_control_ff[wdt_pkg::RATE_MSB:wdt_pkg::RATE_LSB] <=
					wdata[wdt_pkg::RATE_MSB:wdt_pkg::RATE_LSB];
				rate_written_ff <= 1'b1;
			end
			if (!dbg_written_ff)
			begin
				watchdog_control_ff[wdt_pkg::DEBUG_STOP_BIT] <= wdata[wdt_pkg::DEBUG_STOP_BIT];
				dbg_written_ff <= 1'b1;
			end
		end
	end

	// low-power configuration; watchdog wait-stop is write-once in normal modes
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			power_config_ff  <= wdt_pkg::POWER_CONFIG_RST;
			wwait_written_ff <= 1'b0;
		end
		else if (wr_pcfg)
		begin
			power_config_ff[wdt_pkg::TICK_WAIT_STOP_BIT]    <= wdata[wdt_pkg::TICK_WAIT_STOP_BIT];
			power_config_ff[wdt_pkg::TICK_PSTOP_ENABLE_BIT] <= wdata[wdt_pkg::TICK_PSTOP_ENABLE_BIT];
			power_config_ff[wdt_pkg::WDOG_PSTOP_ENABLE_BIT] <= wdata[wdt_pkg::WDOG_PSTOP_ENABLE_BIT];
			power_config_ff[wdt_pkg::TICK_IRQ_ENABLE_BIT]   <= wdata[wdt_pkg::TICK_IRQ_ENABLE_BIT];
			if (mode.special || !wwait_written_ff)
			begin
				power_config_ff[wdt_pkg::WDOG_WAIT_STOP_BIT] <= wdata[wdt_pkg::WDOG_WAIT_STOP_BIT];
				wwait_written_ff <= 1'b1;
			end
		end
	end

	// factory test registers
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			factory_test_bypass_ff  <= wdt_pkg::FACTORY_TEST_BYPASS_RST;
			factory_test_control_ff <= wdt_pkg::FACTORY_TEST_CONTROL_RST;
		end
		else
		begin
			if (wr_ftb)
				factory_test_bypass_ff <= wdata;
			if (wr_ftc)
				factory_test_control_ff <= wdata;
		end
	end

	// periodic tick
	assign tick_pre    = tick_control_ff[wdt_pkg::TICK_PRESCALE_MSB:wdt_pkg::TICK_PRESCALE_LSB];
	assign tick_mod    = tick_control_ff[wdt_pkg::TICK_MODULUS_MSB:wdt_pkg::TICK_MODULUS_LSB];
	assign tick_limit  = (21'({1'b0, tick_mod} + 5'h01) << ({2'b00, tick_pre} + wdt_pkg::TICK_PRESCALE_BASE))
		- 21'h00_0001;
	assign debug_halt  = watchdog_control_ff[wdt_pkg::DEBUG_STOP_BIT] && mode.bdm_active;
	assign tick_clear  = wr_tick_ctl || (tick_pre == 3'h0)
		|| (mode.wait_mode && power_config_ff[wdt_pkg::TICK_WAIT_STOP_BIT]);
	assign tick_run    = !debug_halt
		&& !(mode.pseudo_stop && !power_config_ff[wdt_pkg::TICK_PSTOP_ENABLE_BIT]);
	assign tick_expire = !tick_clear && tick_run && (tick_cnt_ff == tick_limit);

	// counts ref_clk, the oscillator clock
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			tick_cnt_ff <= 21'h00_0000;
		else if (tick_clear)
			tick_cnt_ff <= 21'h00_0000;
		else if (tick_run)
			tick_cnt_ff <= tick_expire ? 21'h00_0000 : tick_cnt_ff + 21'h00_0001;
	end

	// sticky tick flag, set wins over write-one-to-clear
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			tick_flag_ff <= 1'b0;
		else if (tick_expire)
			tick_flag_ff <= 1'b1;
		else if (wr_status && wdata[0])
			tick_flag_ff <= 1'b0;
	end

	assign tick_irq = tick_flag_ff && power_config_ff[wdt_pkg::TICK_IRQ_ENABLE_BIT];

	// watchdog
	assign wdog_rate = watchdog_control_ff[wdt_pkg::RATE_MSB:wdt_pkg::RATE_LSB];
	assign wdog_on   = (wdog_rate != 3'h0);

	always_comb
	begin
		unique case (wdog_rate)
			3'h1:    wdog_exp = wdt_pkg::WDOG_EXP_1;
			3'h2:    wdog_exp = wdt_pkg::WDOG_EXP_2;
			3'h3:    wdog_exp = wdt_pkg::WDOG_EXP_3;
			3'h4:    wdog_exp = wdt_pkg::WDOG_EXP_4;
			3'h5:    wdog_exp = wdt_pkg::WDOG_EXP_5;
			3'h6:    wdog_exp = wdt_pkg::WDOG_EXP_6;
			3'h7:    wdog_exp = wdt_pkg::WDOG_EXP_7;
			default: wdog_exp = 5'h00;
		endcase
	end

	assign wdog_limit  = (25'h000_0001 << wdog_exp) - 25'h000_0001;
	assign wdog_open   = (25'h000_0001 << wdog_exp) - (25'h000_0001 << (wdog_exp - 5'h02));
	assign key_bad     = wr_key && wdog_on && (wdata != wdt_pkg::KEY_FIRST) && (wdata != wdt_pkg::KEY_SECOND);
	assign key_early   = wr_key && wdog_on && watchdog_control_ff[wdt_pkg::WINDOW_MODE_BIT]
		&& (wdog_cnt_ff < wdog_open);
	assign key_restart = wr_key && wdog_on && key_first_ff && (wdata == wdt_pkg::KEY_SECOND)
		&& !key_early;
	assign wdog_clear  = !wdog_on || key_restart || wr_wdog_ctl
		|| (mode.wait_mode && power_config_ff[wdt_pkg::WDOG_WAIT_STOP_BIT]);
	assign wdog_run    = !debug_halt
		&& !(mode.pseudo_stop && !power_config_ff[wdt_pkg::WDOG_PSTOP_ENABLE_BIT]);
	assign wdog_expire = !wdog_clear && wdog_run && (wdog_cnt_ff == wdog_limit);

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			wdog_cnt_ff <= 25'h000_0000;
		else if (wdog_clear)
			wdog_cnt_ff <= 25'h000_0000;
		else if (wdog_run && !wdog_expire)
			wdog_cnt_ff <= wdog_cnt_ff + 25'h000_0001;
	end

	// key sequence tracker
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			key_first_ff <= 1'b0;
		else if (!wdog_on || key_restart)
			key_first_ff <= 1'b0;
		else if (wr_key && (wdata == wdt_pkg::KEY_FIRST))
			key_first_ff <= 1'b1;
	end

	// reset request holds until the system reset clears the block
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			reset_req_ff <= 1'b0;
		else if (key_bad || key_early || wdog_expire)
			reset_req_ff <= 1'b1;
	end

	assign wdog_reset_req = reset_req_ff;

	a_bad_key_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
		(wr_key && wdog_on && wdata != 8'h55 && wdata != 8'hAA) |=> wdog_reset_req)
		else $error("bad restart key did not reset");

	a_key_ignored_off: assert property (@(posedge ref_clk) disable iff (!nrst)
		(wr_key && !wdog_on && !wdog_reset_req) |=> (!wdog_reset_req && wdog_cnt_ff == 25'h000_0000))
		else $error("restart write acted while watchdog off");

	a_window_early: assert property (@(posedge ref_clk) disable iff (!nrst)
		(wr_key && wdog_on && watchdog_control_ff[7] && wdog_cnt_ff < (wdog_limit - (wdog_limit >> 2)))
		|=> wdog_reset_req)
		else $error("early window write did not reset");

	a_key_restart: assert property (@(posedge ref_clk) disable iff (!nrst)
		(wr_key && wdog_on && key_first_ff && wdata == 8'hAA && !watchdog_control_ff[7] && !wr_wdog_ctl)
		|=> (wdog_cnt_ff == 25'h000_0000 && !key_first_ff))
		else $error("key pair did not restart period");

	a_single_key_safe: assert property (@(posedge ref_clk) disable iff (!nrst)
		(wr_key && wdog_on && !key_first_ff && wdata == 8'hAA && !watchdog_control_ff[7]
		&& wdog_cnt_ff < wdog_limit && !wdog_reset_req) |=> (!wdog_reset_req && $stable(wdog_rate)))
		else $error("lone second key caused reset");

	a_timeout_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
		(wdog_on && wdog_run && !wdog_clear && wdog_cnt_ff == wdog_limit) |=> wdog_reset_req)
		else $error("expiry did not reset");

	a_tick_reinit: assert property (@(posedge ref_clk) disable iff (!nrst)
		wr_tick_ctl |=> (tick_cnt_ff == 21'h00_0000) ##1 (tick_cnt_ff <= 21'h00_0001))
		else $error("tick counter not reinitialised");

	a_tick_off: assert property (@(posedge ref_clk) disable iff (!nrst)
		(tick_pre == 3'h0) [*2] |-> (tick_cnt_ff == 21'h00_0000 && !$rose(tick_flag_ff)))
		else $error("tick ran while off");

	a_rate_once: assert property (@(posedge ref_clk) disable iff (!nrst)
		(wr_wdog_ctl && !mode.special && rate_written_ff) |=> $stable(wdog_rate))
		else $error("rate rewritten in normal mode");

	a_ftest_read: assert property (@(posedge ref_clk) disable iff (!nrst)
		(psel && !penable && !pwrite && !mode.special && paddr == 8'h0C) |=> (prdata == 32'h0000_0080))
		else $error("factory control read wrong");

	a_debug_freeze: assert property (@(posedge ref_clk) disable iff (!nrst)
		(debug_halt && !wdog_clear && !tick_clear) |=> ($stable(wdog_cnt_ff) && $stable(tick_cnt_ff)))
		else $error("counters ran in debug halt");

	a_wait_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		(mode.wait_mode && power_config_ff[wdt_pkg::TICK_WAIT_STOP_BIT]
		&& power_config_ff[wdt_pkg::WDOG_WAIT_STOP_BIT])
		|=> (tick_cnt_ff == 21'h00_0000 && wdog_cnt_ff == 25'h000_0000))
		else $error("wait mode did not clear counters");

	a_pstop_freeze: assert property (@(posedge ref_clk) disable iff (!nrst)
		(mode.pseudo_stop && !power_config_ff[wdt_pkg::TICK_PSTOP_ENABLE_BIT] && !tick_clear)
		|=> $stable(tick_cnt_ff))
		else $error("tick ran in pseudo-stop");

endmodule : wdt_top

`default_nettype wire

// ===== tb/test_watchdog_and_periodic_tick.sv
`timescale 1ns/1ps
`default_nettype none

module test_watchdog_and_periodic_tick;
	logic                  ref_clk;
	logic                  nrst;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [7:0]            paddr;
	logic [31:0]           pwdata;
	logic [3:0]            pstrb;
	logic                  pready;
	logic [31:0]           prdata;
	logic                  pslverr;
	wdt_pkg::wdt_mode_type mode;
	logic                  tick_irq;
	logic                  wdog_reset_req;
	int                    error_cnt;
	int                    checks_done;
	int                    n;
	logic [7:0]            rd;
	logic                  err;

	wdt_top i_wdt_top (
		.ref_clk        (ref_clk),
		.nrst           (nrst),
		.psel           (psel),
		.penable        (penable),
		.pwrite         (pwrite),
		.paddr          (paddr),
		.pwdata         (pwdata),
		.pstrb          (pstrb),
		.pready         (pready),
		.prdata         (prdata),
		.pslverr        (pslverr),
		.mode           (mode),
		.tick_irq       (tick_irq),
		.wdog_reset_req (wdog_reset_req)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic end_sim();
		if (error_cnt == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task automatic fail(input string msg);
		error_cnt++;
		$display("ERROR %0t %s", $time, msg);
	endtask : fail

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
			fail($sformatf("read %h expected %h", got, exp));
	endtask : chk8

	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp)
			fail($sformatf("flag %b expected %b", got, exp));
	endtask : chk_bit

	task automatic chk_near(input int got, input int exp);
		checks_done++;
		if (got < exp - 4 || got > exp + 4)
			fail($sformatf("event after %0d cycles expected %0d", got, exp));
	endtask : chk_near

	// one apb transfer; pready, read data and error taken at the same rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h00_0000, d};
		pstrb   <= wr ? 4'hF : 4'h0;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		@(posedge ref_clk);
		while (pready !== 1'b1 && k < 16)
		begin
			@(posedge ref_clk);
			k++;
		end
		if (pready !== 1'b1)
		begin
			fail("no pready");
			end_sim();
		end
		rd      = prdata[7:0];
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		pwrite  <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk8(rd, exp);
	endtask : rchk

	// cycles until tick_irq or wdog_reset_req; running out of lim ends the run
	task automatic wait_evt(input logic use_tick, input int lim);
		n = 0;
		while (n < lim && (use_tick ? tick_irq : wdog_reset_req) !== 1'b1)
		begin
			@(negedge ref_clk);
			n++;
		end
		if ((use_tick ? tick_irq : wdog_reset_req) !== 1'b1)
		begin
			fail("event timeout");
			end_sim();
		end
	endtask : wait_evt

	task automatic do_reset(input logic special);
		@(posedge ref_clk);
		nrst <= 1'b0;
		mode <= {special, 3'b000};
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
	endtask : do_reset

	initial
	begin
		error_cnt   = 0;
		checks_done = 0;
		nrst        = 1'b0;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 8'h00;
		pwdata      = 32'h0000_0000;
		pstrb       = 4'h0;
		mode        = 4'h8;
		do_reset(1'b1);
		// reset values and unmapped access
		rchk(wdt_pkg::TICK_CONTROL_OFS, 8'h00);
		rchk(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h00);
		rchk(wdt_pkg::FACTORY_TEST_CONTROL_OFS, 8'h80);
		rchk(wdt_pkg::WATCHDOG_RESTART_KEY_OFS, 8'h00);
		rchk(8'h1C, 8'h00);
		chk_bit(err, 1'b1);
		// tick periods
		wr(wdt_pkg::POWER_CONFIG_OFS, 8'h10);
		wr(wdt_pkg::TICK_CONTROL_OFS, 8'h10);
		wait_evt(1'b1, 1044);
		chk_near(n, 1024);
		rchk(wdt_pkg::TICK_STATUS_OFS, 8'h01);
		wr(wdt_pkg::TICK_STATUS_OFS, 8'h01);
		wr(wdt_pkg::TICK_CONTROL_OFS, 8'h12);
		repeat (2000) @(posedge ref_clk);
		wr(wdt_pkg::TICK_CONTROL_OFS, 8'h12);
		wait_evt(1'b1, 3092);
		chk_near(n, 3072);
		wr(wdt_pkg::TICK_STATUS_OFS, 8'h01);
		wr(wdt_pkg::TICK_CONTROL_OFS, 8'h0F);
		repeat (1100) @(posedge ref_clk);
		chk_bit(tick_irq, 1'b0);
		rchk(wdt_pkg::TICK_CONTROL_OFS, 8'h0F);
		// wait mode clears the tick, pseudo-stop without enable freezes it
		wr(wdt_pkg::POWER_CONFIG_OFS, 8'h13);
		rchk(wdt_pkg::POWER_CONFIG_OFS, 8'h13);
		wr(wdt_pkg::TICK_CONTROL_OFS, 8'h10);
		mode <= 4'hA;
		repeat (1100) @(posedge ref_clk);
		mode <= 4'h8;
		repeat (600) @(posedge ref_clk);
		mode <= 4'h9;
		repeat (1000) @(posedge ref_clk);
		chk_bit(tick_irq, 1'b0);
		mode <= 4'h8;
		wait_evt(1'b1, 500);
		chk_near(n, 424);
		wr(wdt_pkg::TICK_STATUS_OFS, 8'h01);
		wr(wdt_pkg::TICK_CONTROL_OFS, 8'h00);
		// disabled watchdog ignores keys
		wr(wdt_pkg::WATCHDOG_RESTART_KEY_OFS, 8'h13);
		repeat (20) @(posedge ref_clk);
		chk_bit(wdog_reset_req, 1'b0);
		// timeout from enable
		wr(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h01);
		wait_evt(1'b0, 16404);
		chk_near(n, 16384);
		// key sequence restarts the period
		do_reset(1'b1);
		wr(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h01);
		repeat (12000) @(posedge ref_clk);
		wr(wdt_pkg::WATCHDOG_RESTART_KEY_OFS, 8'hAA);
		wr(wdt_pkg::WATCHDOG_RESTART_KEY_OFS, 8'h55);
		wr(wdt_pkg::WATCHDOG_RESTART_KEY_OFS, 8'h55);
		wr(wdt_pkg::WATCHDOG_RESTART_KEY_OFS, 8'hAA);
		wait_evt(1'b0, 16404);
		chk_near(n, 16384);
		// bad key
		do_reset(1'b1);
		wr(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h01);
		wr(wdt_pkg::WATCHDOG_RESTART_KEY_OFS, 8'h12);
		wait_evt(1'b0, 10);
		chk_near(n, 1);
		// window mode, early key
		do_reset(1'b1);
		wr(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h81);
		repeat (100) @(posedge ref_clk);
		wr(wdt_pkg::WATCHDOG_RESTART_KEY_OFS, 8'h55);
		wait_evt(1'b0, 10);
		chk_near(n, 1);
		// window mode, keys in window then too soon
		do_reset(1'b1);
		wr(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h81);
		repeat (12400) @(posedge ref_clk);
		wr(wdt_pkg::WATCHDOG_RESTART_KEY_OFS, 8'h55);
		wr(wdt_pkg::WATCHDOG_RESTART_KEY_OFS, 8'hAA);
		repeat (100) @(posedge ref_clk);
		chk_bit(wdog_reset_req, 1'b0);
		wr(wdt_pkg::WATCHDOG_RESTART_KEY_OFS, 8'h55);
		wait_evt(1'b0, 10);
		chk_near(n, 1);
		// debug halt freezes both counters
		do_reset(1'b1);
		wr(wdt_pkg::POWER_CONFIG_OFS, 8'h10);
		wr(wdt_pkg::TICK_CONTROL_OFS, 8'h10);
		wr(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h41);
		@(posedge ref_clk);
		mode <= 4'hC;
		repeat (17000) @(posedge ref_clk);
		chk_bit(wdog_reset_req, 1'b0);
		chk_bit(tick_irq, 1'b0);
		rchk(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h41);
		// normal mode protections
		do_reset(1'b0);
		wr(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h01);
		wr(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h82);
		rchk(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h01);
		wr(wdt_pkg::FACTORY_TEST_BYPASS_OFS, 8'h5A);
		rchk(wdt_pkg::FACTORY_TEST_BYPASS_OFS, 8'h00);
		wr(wdt_pkg::FACTORY_TEST_CONTROL_OFS, 8'h11);
		rchk(wdt_pkg::FACTORY_TEST_CONTROL_OFS, 8'h80);
		// special mode rewrites
		do_reset(1'b1);
		wr(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h01);
		wr(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h82);
		rchk(wdt_pkg::WATCHDOG_CONTROL_OFS, 8'h82);
		wr(wdt_pkg::FACTORY_TEST_BYPASS_OFS, 8'h5A);
		rchk(wdt_pkg::FACTORY_TEST_BYPASS_OFS, 8'h5A);
		end_sim();
	end
endmodule : test_watchdog_and_periodic_tick

`default_nettype wire
